// ==== hdl/ddcp_top.sv ====
/*
  Down-converter preset and range control: register port, preset store,
  active preset selection, range flags and oscillator phase.
  Assumes a synchronous byte register port and one sample clock.
*/
// Chosen here: the plain strobed port.
module ddcp_top #(
    parameter int BASE_PERIOD = 8,
    parameter int SAMPLE_W    = 15
) (
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire ddcp_pkg::ddcp_req_type reg_req,
    output logic [7:0]                 rd_data_q,
    input  wire logic [2:0]            preset_select_pins,
    input  wire logic                  sample_valid,
    input  wire ddcp_pkg::ddcp_iq_type  sample_in,
    output ddcp_pkg::ddcp_out_type     sample_out_q,
    output logic                       sample_out_valid_q,
    output logic [2:0]                 active_preset_q,
    output logic [7:0]                 preset_group_delay_q,
    output logic [31:0]                nco_phase_q,
    output logic                       link_enable_q
);
    // Refuse widths the magnitude slicing cannot serve
    if (SAMPLE_W != 15 || BASE_PERIOD < 1) begin : g_bad_param
        $error("ddcp_top: unsupported SAMPLE_W or BASE_PERIOD");
    end

    // Control registers
    logic [7:0]  i_level_threshold_q;
    logic [7:0]  q_level_threshold_q;
    logic [2:0]  monitor_period_exponent_q;
    logic        preset_source_register_q;
    logic [2:0]  active_preset_index_q;
    logic [15:0] rational_step_divisor_q;

    // Preset store
    logic [31:0] preset_frequency_word [ddcp_pkg::N_PRESETS];
    logic [15:0] preset_phase_word     [ddcp_pkg::N_PRESETS];
    logic [7:0]  preset_group_delay    [ddcp_pkg::N_PRESETS];

    // Address decode
    logic        in_preset;
    logic [2:0]  pb_index;
    logic [2:0]  pb_byte;
    logic        wr_i_thr;
    logic        wr_q_thr;
    logic        wr_period;
    logic        wr_mode;
    logic        wr_sel;
    logic        wr_div_lo;
    logic        wr_div_hi;
    logic        wr_link;
    logic        wr_preset;

    assign in_preset = (reg_req.addr[11:6] == ddcp_pkg::PRESET_BLOCK);
    assign pb_index  = reg_req.addr[5:3];
    assign pb_byte   = reg_req.addr[2:0];
    assign wr_i_thr  = reg_req.wr && (reg_req.addr == ddcp_pkg::ADDR_I_THR);
    assign wr_q_thr  = reg_req.wr && (reg_req.addr == ddcp_pkg::ADDR_Q_THR);
    assign wr_period = reg_req.wr && (reg_req.addr == ddcp_pkg::ADDR_PERIOD);
    assign wr_mode   = reg_req.wr && (reg_req.addr == ddcp_pkg::ADDR_SRC_MODE);
    assign wr_sel    = reg_req.wr && (reg_req.addr == ddcp_pkg::ADDR_SEL);
    assign wr_div_lo = reg_req.wr && (reg_req.addr == ddcp_pkg::ADDR_DIV_LO);
    assign wr_div_hi = reg_req.wr && (reg_req.addr == ddcp_pkg::ADDR_DIV_HI);
    assign wr_link   = reg_req.wr && (reg_req.addr == ddcp_pkg::ADDR_LINK_CTRL);
    assign wr_preset = reg_req.wr && in_preset;

    // Threshold and period registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            i_level_threshold_q       <= ddcp_pkg::RST_I_THR;
            q_level_threshold_q       <= ddcp_pkg::RST_Q_THR;
            monitor_period_exponent_q <= 3'h0;
        end else begin
            if (wr_i_thr) begin
                i_level_threshold_q <= reg_req.wdata;
            end
            if (wr_q_thr) begin
                q_level_threshold_q <= reg_req.wdata;
            end
            if (wr_period) begin
                monitor_period_exponent_q <= reg_req.wdata[2:0];
            end
        end
    end

    // Preset mode, select, divisor and link registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            preset_source_register_q <= 1'b0;
            active_preset_index_q    <= 3'h0;
            rational_step_divisor_q  <= 16'h0000;
            link_enable_q            <= 1'b0;
        end else begin
            if (wr_mode) begin
                preset_source_register_q <= reg_req.wdata[0];
            end
            if (wr_sel) begin
                active_preset_index_q <= reg_req.wdata[2:0];
            end
            if (wr_div_lo) begin
                rational_step_divisor_q[7:0] <= reg_req.wdata;
            end
            if (wr_div_hi) begin
                rational_step_divisor_q[15:8] <= reg_req.wdata;
            end
            if (wr_link) begin
                link_enable_q <= reg_req.wdata[0];
            end
        end
    end

    // Byte writes into the eight presets
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int p = 0; p < ddcp_pkg::N_PRESETS; p++) begin
                preset_frequency_word[p] <= ddcp_pkg::RST_FREQ;
                preset_phase_word[p]     <= ddcp_pkg::RST_PHASE;
                preset_group_delay[p]    <= ddcp_pkg::RST_DELAY;
            end
        end else if (wr_preset) begin
            case (pb_byte)
                3'h0, 3'h1, 3'h2, 3'h3: begin
                    preset_frequency_word[pb_index][pb_byte[1:0]*8 +: 8]
                        <= reg_req.wdata;
                end
                ddcp_pkg::PB_PHASE_LO: begin
                    preset_phase_word[pb_index][7:0] <= reg_req.wdata;
                end
                ddcp_pkg::PB_PHASE_HI: begin
                    preset_phase_word[pb_index][15:8] <= reg_req.wdata;
                end
                ddcp_pkg::PB_DELAY: begin
                    preset_group_delay[pb_index] <= reg_req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux of the current register state
    logic [7:0] rd_mux;
    logic [7:0] rd_preset;
    logic [7:0] status_byte;
    logic [1:0] flag_now;

    assign status_byte = {2'b00, flag_now, 1'b0, active_preset_q};

    always_comb begin
        case (pb_byte)
            3'h0, 3'h1, 3'h2, 3'h3: begin
                rd_preset = preset_frequency_word[pb_index][pb_byte[1:0]*8 +: 8];
            end
            ddcp_pkg::PB_PHASE_LO: begin
                rd_preset = preset_phase_word[pb_index][7:0];
            end
            ddcp_pkg::PB_PHASE_HI: begin
                rd_preset = preset_phase_word[pb_index][15:8];
            end
            ddcp_pkg::PB_DELAY: begin
                rd_preset = preset_group_delay[pb_index];
            end
            default: begin
                rd_preset = 8'h00;
            end
        endcase
    end

    always_comb begin
        case (reg_req.addr)
            ddcp_pkg::ADDR_I_THR:     rd_mux = i_level_threshold_q;
            ddcp_pkg::ADDR_Q_THR:     rd_mux = q_level_threshold_q;
            ddcp_pkg::ADDR_PERIOD:    rd_mux = {5'h00, monitor_period_exponent_q};
            ddcp_pkg::ADDR_SRC_MODE:  rd_mux = {7'h00, preset_source_register_q};
            ddcp_pkg::ADDR_SEL:       rd_mux = {5'h00, active_preset_index_q};
            ddcp_pkg::ADDR_DIV_LO:    rd_mux = rational_step_divisor_q[7:0];
            ddcp_pkg::ADDR_DIV_HI:    rd_mux = rational_step_divisor_q[15:8];
            ddcp_pkg::ADDR_LINK_CTRL: rd_mux = {7'h00, link_enable_q};
            ddcp_pkg::ADDR_STATUS:    rd_mux = status_byte;
            default:                  rd_mux = in_preset ? rd_preset : 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= reg_req.rd ? rd_mux : 8'h00;
        end
    end

    // Active preset source: pins in mode 0, register in mode 1
    logic [2:0] preset_next;

    assign preset_next = preset_source_register_q ? active_preset_index_q
                                                  : preset_select_pins;

    // Preset index one edge after sampling, its delay register one edge after the index
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            active_preset_q      <= 3'h0;
            preset_group_delay_q <= ddcp_pkg::RST_DELAY;
        end else begin
            active_preset_q      <= preset_next;
            preset_group_delay_q <= preset_group_delay[active_preset_q];
        end
    end

    // Monitoring window; exponent assumed stable while the link runs
    logic window_end;

    ddcp_window #(
        .BASE_PERIOD (BASE_PERIOD)
    ) u_window (
        .clock      (clock),
        .arst_n     (arst_n),
        .tick       (sample_valid),
        .exponent   (monitor_period_exponent_q),
        .window_end (window_end)
    );

    // Per-channel magnitude compare and window-held flag
    logic [SAMPLE_W-1:0] chan_sample [2];
    logic [7:0]          chan_thr    [2];
    logic [1:0]          hit_q;

    assign chan_sample[0] = sample_in.i;
    assign chan_sample[1] = sample_in.q;
    assign chan_thr[0]    = i_level_threshold_q;
    assign chan_thr[1]    = q_level_threshold_q;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic [SAMPLE_W-1:0] mag;
        logic [7:0]          level;
        logic                reach;

        // Full scale maps to 256 threshold steps, top value saturates
        assign mag   = chan_sample[c][SAMPLE_W-1] ? SAMPLE_W'(-chan_sample[c])
                                                  : chan_sample[c];
        assign level = mag[SAMPLE_W-1] ? 8'hff : mag[SAMPLE_W-2 -: 8];
        assign reach = sample_valid && (level >= chan_thr[c]);
        assign flag_now[c] = hit_q[c] || reach;

        // Hold until the window closes, then start afresh
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                hit_q[c] <= 1'b0;
            end else if (window_end) begin
                hit_q[c] <= 1'b0;
            end else if (reach) begin
                hit_q[c] <= 1'b1;
            end
        end
    end

    // Output samples carry their flags
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sample_out_q       <= '0;
            sample_out_valid_q <= 1'b0;
        end else begin
            sample_out_valid_q <= sample_valid;
            if (sample_valid) begin
                sample_out_q.i      <= sample_in.i;
                sample_out_q.i_flag <= flag_now[0];
                sample_out_q.q      <= sample_in.q;
                sample_out_q.q_flag <= flag_now[1];
            end
        end
    end

    // Oscillator of the active preset, one divisor for all presets
    logic [31:0] acc;

    ddcp_nco u_nco (
        .clock   (clock),
        .arst_n  (arst_n),
        .tick    (sample_valid),
        .freq    (preset_frequency_word[active_preset_q]),
        .divisor (rational_step_divisor_q),
        .acc_q   (acc)
    );

    // Phase offset justified to the top of 32 bits
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            nco_phase_q <= 32'h0000_0000;
        end else begin
            nco_phase_q <= acc + {preset_phase_word[active_preset_q], 16'h0000};
        end
    end
endmodule

// ==== hdl/ddcp_pkg.sv ====
/*
  Shared constants and carriers for the down-converter preset and
  range control block. Assumes an 8-bit byte-addressed register port.
*/
// Overview of operation
// - Q range flag sets when sample magnitude reaches the Q threshold
// - Q range flag travels with the quadrature output sample
// - A 3-bit exponent field sets the range monitoring window
// - Window is base period times two to the exponent
// - Eight presets, each with its own frequency and phase word
// - Group delay comes from the active preset
// - Mode 0 takes the active preset from the select pins
// - Mode 1 takes the active preset from the select register
// - Select register field is 3 bits and only counts in mode 1
// - One 16-bit step divisor serves every preset
// - Divisor removes the frequency error of the 32-bit word
// - I range flag uses the I threshold and travels with I samples
// - Preset phase is MSB-justified into 32 bits and added on
package ddcp_pkg;
    // Register byte addresses
    localparam logic [11:0] ADDR_I_THR      = 12'h206;
    localparam logic [11:0] ADDR_Q_THR      = 12'h207;
    localparam logic [11:0] ADDR_PERIOD     = 12'h208;
    localparam logic [11:0] ADDR_SRC_MODE   = 12'h20c;
    localparam logic [11:0] ADDR_SEL        = 12'h20d;
    localparam logic [11:0] ADDR_DIV_LO     = 12'h20e;
    localparam logic [11:0] ADDR_DIV_HI     = 12'h20f;
    localparam logic [11:0] ADDR_LINK_CTRL  = 12'h210;
    localparam logic [11:0] ADDR_STATUS     = 12'h211;
    // Preset window: 0x240 + 8*preset + byte
    localparam logic [5:0]  PRESET_BLOCK    = 6'h09;
    localparam logic [2:0]  PB_PHASE_LO     = 3'h4;
    localparam logic [2:0]  PB_PHASE_HI     = 3'h5;
    localparam logic [2:0]  PB_DELAY        = 3'h6;
    // Reset values
    localparam logic [7:0]  RST_I_THR       = 8'hf2;
    localparam logic [7:0]  RST_Q_THR       = 8'hab;
    localparam logic [31:0] RST_FREQ        = 32'hc000_0000;
    localparam logic [15:0] RST_PHASE       = 16'h0000;
    localparam logic [7:0]  RST_DELAY       = 8'hff;
    // Divisor is scaled by 128 samples
    localparam int          DIV_SHIFT       = 7;
    localparam int          N_PRESETS       = 8;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } ddcp_req_type;

    typedef struct packed {
        logic [14:0] i;
        logic [14:0] q;
    } ddcp_iq_type;

    typedef struct packed {
        logic [14:0] i;
        logic        i_flag;
        logic [14:0] q;
        logic        q_flag;
    } ddcp_out_type;
endpackage

// ==== hdl/ddcp_window.sv ====
/*
  Range monitoring window timer. Counts sample ticks and marks the last
  tick of each window. Assumes tick is a one-cycle enable per sample.
*/
module ddcp_window #(
    parameter int BASE_PERIOD = 8
) (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       tick,
    input  wire logic [2:0] exponent,
    output logic            window_end
);
    localparam int CW = $clog2(BASE_PERIOD) + 8;

    logic [CW-1:0] count_q;
    logic [CW-1:0] limit;

    // Window length is base times two to the exponent
    assign limit      = CW'((BASE_PERIOD << exponent) - 1);
    assign window_end = tick && (count_q >= limit);

    // Sample counter, restarts each window
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else if (window_end) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + 1'b1;
        end
    end
endmodule

// ==== hdl/ddcp_nco.sv ====
/*
  Oscillator phase accumulator with rational step divisor.
  Assumes tick is a one-cycle enable per sample.
*/
module ddcp_nco (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        tick,
    input  wire logic [31:0] freq,
    input  wire logic [15:0] divisor,
    output logic [31:0]      acc_q
);
    localparam int PW = 16 + ddcp_pkg::DIV_SHIFT;

    logic [PW-1:0] count_q;
    logic [PW-1:0] period;
    logic          wrap;

    // Exact repeat length is divisor times 128 samples
    assign period = {divisor, {ddcp_pkg::DIV_SHIFT{1'b0}}};
    assign wrap   = tick && (divisor != 16'h0000)
                    && (count_q >= period - 1'b1);

    // Accumulator restarts on the exact period, dropping rounding drift
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_q   <= '0;
            count_q <= '0;
        end else if (wrap) begin
            acc_q   <= '0;
            count_q <= '0;
        end else if (tick) begin
            acc_q   <= acc_q + freq;
            count_q <= count_q + 1'b1;
        end
    end
endmodule

// ==== test/ddcp_pin_model.sv ====
/*
  Model of the outside logic that drives the preset select pins.
  Assumes the bench asks for a new pin value at a rising clock edge.
*/
module ddcp_pin_model (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic [2:0] want,
    output logic [2:0]      pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins move one edge after the request, as a registered driver would
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pins <= 3'h0;
        end else begin
            pins <= want;
        end
    end
endmodule

// ==== test/ddcp_top_asserts.sv ====
/*
  Port checker for the range and preset control block.
  Assumes it is bound to ddcp_top and sees only that module's ports.
*/
module ddcp_top_asserts #(
    parameter int BASE_PERIOD = 8,
    parameter int SAMPLE_W    = 15
) (
    input wire logic                   clock,
    input wire logic                   arst_n,
    input wire ddcp_pkg::ddcp_req_type reg_req,
    input wire logic [7:0]             rd_data_q,
    input wire logic [2:0]             preset_select_pins,
    input wire logic                   sample_valid,
    input wire ddcp_pkg::ddcp_iq_type  sample_in,
    input wire ddcp_pkg::ddcp_out_type sample_out_q,
    input wire logic                   sample_out_valid_q,
    input wire logic [2:0]             active_preset_q,
    input wire logic [7:0]             preset_group_delay_q,
    input wire logic [31:0]            nco_phase_q,
    input wire logic                   link_enable_q
);
    logic       mode_q;
    logic       link_q;
    logic [2:0] sel_q;
    logic [7:0] qthr_q;
    logic [7:0] ithr_q;
    wire  [2:0] next_preset = mode_q ? sel_q : preset_select_pins;
    // Level of a sample magnitude, saturated at full scale
    function automatic logic [7:0] lvl(input logic [14:0] s);
        logic [14:0] a;
        a = s[14] ? -s : s;
        return (s == 15'h4000) ? 8'hff : a[13:6];
    endfunction
    // Mirror of control values written over the register port
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= 1'b0;
            link_q <= 1'b0;
            sel_q  <= 3'h0;
            qthr_q <= ddcp_pkg::RST_Q_THR;
            ithr_q <= ddcp_pkg::RST_I_THR;
        end else if (reg_req.wr) begin
            if (reg_req.addr == ddcp_pkg::ADDR_SRC_MODE) mode_q <= reg_req.wdata[0];
            if (reg_req.addr == ddcp_pkg::ADDR_LINK_CTRL) link_q <= reg_req.wdata[0];
            if (reg_req.addr == ddcp_pkg::ADDR_SEL) sel_q <= reg_req.wdata[2:0];
            if (reg_req.addr == ddcp_pkg::ADDR_Q_THR) qthr_q <= reg_req.wdata;
            if (reg_req.addr == ddcp_pkg::ADDR_I_THR) ithr_q <= reg_req.wdata;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Steps of a flagged sample and of a link write
    sequence s_q_hit;
        sample_valid && lvl(sample_in.q) >= qthr_q;
    endsequence
    sequence s_i_hit;
        sample_valid && lvl(sample_in.i) >= ithr_q;
    endsequence
    sequence s_link_wr;
        reg_req.wr && reg_req.addr == ddcp_pkg::ADDR_LINK_CTRL;
    endsequence
    AST_Q_FLAG: assert property (s_q_hit |=> sample_out_q.q_flag)
        else $error("Q flag missing after a level at threshold");
    AST_I_FLAG: assert property (s_i_hit |=> sample_out_q.i_flag)
        else $error("I flag missing after a level at threshold");
    AST_Q_THR_RD: assert property (reg_req.rd && reg_req.addr == ddcp_pkg::ADDR_Q_THR
        |=> rd_data_q == qthr_q) else $error("Q threshold read back wrong");
    AST_PERIOD_RD: assert property (reg_req.rd && reg_req.addr == ddcp_pkg::ADDR_PERIOD
        |=> rd_data_q[7:3] == 5'h00) else $error("Period field wider than three bits");
    AST_PRESET_SRC: assert property (1'b1 |=>
        active_preset_q == $past(next_preset))
        else $error("Active preset not taken from the selected source");
    AST_OUT_VALID: assert property (sample_out_valid_q == $past(sample_valid))
        else $error("Output strobe not one cycle after input strobe");
    AST_OUT_COPY: assert property (sample_valid |=>
        sample_out_q.q == $past(sample_in.q) && sample_out_q.i == $past(sample_in.i))
        else $error("Output sample not a copy");
    AST_OUT_HOLD: assert property (!sample_valid |=> $stable(sample_out_q))
        else $error("Output sample or flags moved without a sample");
    AST_LINK: assert property (s_link_wr |=> ##[0:1] link_enable_q == link_q)
        else $error("Link enable does not follow its control bit");
endmodule

bind ddcp_top ddcp_top_asserts #(.BASE_PERIOD(BASE_PERIOD), .SAMPLE_W(SAMPLE_W))
    u_ddcp_top_asserts (.clock(clock), .arst_n(arst_n), .reg_req(reg_req),
    .rd_data_q(rd_data_q), .preset_select_pins(preset_select_pins),
    .sample_valid(sample_valid), .sample_in(sample_in), .sample_out_q(sample_out_q),
    .sample_out_valid_q(sample_out_valid_q), .active_preset_q(active_preset_q),
    .preset_group_delay_q(preset_group_delay_q), .nco_phase_q(nco_phase_q),
    .link_enable_q(link_enable_q));

// ==== test/ddcp_top_tb.sv ====
/*
  Self-checking bench for the range and preset control block.
  Assumes the pin model and the bound checker are compiled before it.
*/
module ddcp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BP = 2;
    localparam logic [11:0] RA [10] = '{12'h206, 12'h207, 12'h208, 12'h20c, 12'h20d,
                                        12'h20e, 12'h20f, 12'h210, 12'h243, 12'h246};
    localparam logic [7:0]  RV [10] = '{8'hf2, 8'hab, 8'h00, 8'h00, 8'h00,
                                        8'h00, 8'h00, 8'h00, 8'hc0, 8'hff};
    localparam logic [11:0] WA [7]  = '{12'h207, 12'h208, 12'h20c, 12'h20d,
                                        12'h20e, 12'h20f, 12'h300};
    localparam logic [7:0]  WM [7]  = '{8'hff, 8'h07, 8'h01, 8'h07, 8'hff, 8'h1f, 8'h00};
    logic                   clock;
    logic                   arst_n;
    ddcp_pkg::ddcp_req_type reg_req;
    logic [7:0]             rd_data_q;
    logic [2:0]             pin_want;
    logic [2:0]             preset_select_pins;
    logic                   sample_valid;
    ddcp_pkg::ddcp_iq_type  sample_in;
    ddcp_pkg::ddcp_out_type sample_out_q;
    logic                   sample_out_valid_q;
    logic [2:0]             active_preset_q;
    logic [7:0]             preset_group_delay_q;
    logic [31:0]            nco_phase_q;
    logic                   link_enable_q;
    logic [31:0]            lfsr;
    logic [31:0]            freq;
    logic [14:0]            si;
    logic [14:0]            sq;
    logic                   hi;
    logic                   hq;
    logic [7:0]             dly [8];
    int                     fails = 0;
    int                     comparisons = 0;
    int                     cycles = 0;

    ddcp_top #(.BASE_PERIOD(BP)) u_ddcp_top (.clock(clock), .arst_n(arst_n),
        .reg_req(reg_req), .rd_data_q(rd_data_q), .preset_select_pins(preset_select_pins),
        .sample_valid(sample_valid), .sample_in(sample_in), .sample_out_q(sample_out_q),
        .sample_out_valid_q(sample_out_valid_q), .active_preset_q(active_preset_q),
        .preset_group_delay_q(preset_group_delay_q), .nco_phase_q(nco_phase_q),
        .link_enable_q(link_enable_q));
    ddcp_pin_model u_ddcp_pin_model (.clock(clock), .arst_n(arst_n), .want(pin_want),
        .pins(preset_select_pins));

    // Sample clock, 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test;
        end
    end
    // Random source and expected level of a sample
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] lvl(input logic [14:0] s);
        logic [14:0] a;
        a = s[14] ? -s : s;
        return (s == 15'h4000) ? 8'hff : a[13:6];
    endfunction
    // Comparison, bus cycles, reset and sample strobe
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        reg_req.wr <= 1'b0;
        @(posedge clock);
    endtask
    task rdchk(input logic [11:0] a, input logic [7:0] e);
        reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        reg_req.rd <= 1'b0;
        #1 check(rd_data_q, e);
        @(posedge clock);
    endtask
    task do_reset;
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
    endtask
    task send(input logic [14:0] i, input logic [14:0] q);
        sample_in    <= '{i, q};
        sample_valid <= 1'b1;
        @(posedge clock);
        sample_valid <= 1'b0;
        @(posedge clock);
    endtask
    task end_of_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        reg_req = '0;
        pin_want = 3'h0;
        sample_valid = 1'b0;
        sample_in = '0;
        lfsr = 32'ha402;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        // Reset values, unmapped place reads zero
        for (int n = 0; n < 10; n++) rdchk(RA[n], RV[n]);
        rdchk(12'h300, 8'h00);
        // Write and read back, reserved bits and divisor limit
        for (int n = 0; n < 7; n++) begin
            lfsr = nxt(lfsr);
            wr(WA[n], (n == 5) ? (lfsr[7:0] & 8'h1f) : lfsr[7:0]);
            rdchk(WA[n], lfsr[7:0] & WM[n] & ((n == 5) ? 8'h1f : 8'hff));
        end
        // Distinct delay per preset
        for (int p = 0; p < 8; p++) begin
            lfsr = nxt(lfsr);
            dly[p] = lfsr[7:0];
            wr(12'h246 + 12'(8 * p), dly[p]);
        end
        // Pin source, register value ignored
        wr(ddcp_pkg::ADDR_SRC_MODE, 8'h00);
        wr(ddcp_pkg::ADDR_SEL, 8'h03);
        for (int p = 0; p < 8; p++) begin
            pin_want <= 3'(p);
            repeat (4) @(posedge clock);
            check(active_preset_q, p);
            check(preset_group_delay_q, dly[p]);
        end
        // Register source, pins ignored
        wr(ddcp_pkg::ADDR_SRC_MODE, 8'h01);
        for (int p = 0; p < 8; p++) begin
            lfsr = nxt(lfsr);
            pin_want <= lfsr[2:0];
            wr(ddcp_pkg::ADDR_SEL, 8'(p));
            repeat (2) @(posedge clock);
            check(active_preset_q, p);
            check(preset_group_delay_q, dly[p]);
        end
        // Link enable on and off
        wr(ddcp_pkg::ADDR_LINK_CTRL, 8'h01);
        @(posedge clock);
        check(link_enable_q, 1);
        wr(ddcp_pkg::ADDR_LINK_CTRL, 8'h00);
        // Range flags over windows of 2, 4 and 8 samples, link off
        for (int e = 0; e < 3; e++) begin
            do_reset;
            wr(ddcp_pkg::ADDR_PERIOD, 8'(e));
            wr(ddcp_pkg::ADDR_Q_THR, 8'h80);
            hi = 1'b0;
            hq = 1'b0;
            for (int k = 0; k < 3 * (BP << e); k++) begin
                lfsr = nxt(lfsr);
                si = lfsr[4] ? lfsr[30:16] : {5'h00, lfsr[25:16]};
                sq = lfsr[3] ? lfsr[14:0] : {5'h00, lfsr[9:0]};
                hi = hi | (lvl(si) >= ddcp_pkg::RST_I_THR);
                hq = hq | (lvl(sq) >= 8'h80);
                send(si, sq);
                check(sample_out_q, {si, hi, sq, hq});
                if (k % (BP << e) == (BP << e) - 1) begin
                    hi = 1'b0;
                    hq = 1'b0;
                end
            end
        end
        // Oscillator of preset 5 with phase and shared divisor of one
        do_reset;
        wr(ddcp_pkg::ADDR_SRC_MODE, 8'h01);
        wr(ddcp_pkg::ADDR_SEL, 8'h05);
        freq = nxt(lfsr);
        for (int b = 0; b < 4; b++) wr(12'h268 + 12'(b), freq[8 * b +: 8]);
        wr(12'h26c, lfsr[7:0]);
        wr(12'h26d, lfsr[15:8]);
        wr(ddcp_pkg::ADDR_DIV_LO, 8'h01);
        wr(ddcp_pkg::ADDR_DIV_HI, 8'h00);
        for (int k = 0; k < 130; k++) send(15'h0000, 15'h0000);
        repeat (2) @(posedge clock);
        check(nco_phase_q, 2 * freq + {lfsr[15:0], 16'h0000});
        end_of_test;
    end
endmodule
